// ---- cic_interrupt_control.sv ----
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
module cic_interrupt_control
	import cic_pkg::*;
#(
	parameter int PIN_CHANGE_W = 8,
	parameter int PERIPH_W = 11,
	// Sources that run without the system clock: bit0 ext, bit4 pin change
	parameter logic [7:0] WAKE_CAPABLE_MASK = 8'h11
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic ext_pin_in,
	input wire logic timer0_event_in,
	input wire logic [PIN_CHANGE_W-1:0] pin_change_flags_in,
	input wire logic [PERIPH_W-1:0] periph_flags_in,
	input wire logic [PERIPH_W-1:0] periph_enables_in,
	output logic [1:0] q_phase_out,
	output logic irq_vector_req_out,
	output logic [14:0] irq_vector_addr_out,
	input wire logic vector_taken_in,
	input wire logic [63:0] ctx_save_in,
	input wire logic return_from_interrupt_in,
	output logic restore_valid_out,
	output logic [63:0] ctx_restore_out,
	input wire logic sleeping_in,
	output logic wake_out
);

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
		reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	logic [1:0] q_phase_reg;
	logic ack_reg;
	logic [31:0] readdata_reg;
	logic global_irq_enable_reg;
	logic periph_group_irq_enable_reg;
	logic ext_edge_polarity_reg;
	logic timer0_irq_enable_reg;
	logic pin_change_irq_enable_reg;
	logic ext_pin_irq_enable_reg;
	logic timer0_irq_flag_reg;
	logic ext_pin_irq_flag_reg;
	logic ext_pin_prev_reg;
	logic ext_prev_valid_reg;
	logic irq_req_reg;
	logic post_wake_reg;
	logic wake_reg;
	logic restore_valid_reg;
	logic [63:0] ctx_restore_reg;
	logic [7:0] shadow_reg [NUM_SHADOW];
	logic [14:0] vector_addr_reg;

	logic q1;
	logic wr_en;
	logic rd_first;
	logic ext_edge;
	logic pin_change_irq_flag;
	logic [7:0] flag0;
	logic [7:0] enable0;
	logic [7:0] interrupt_control_view;
	logic pending;
	logic wake_pending;
	logic [31:0] read_mux;

	// Instruction cycle of four phases; phase 0 is the first
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q_phase_reg <= Q_PHASE_FIRST;
		end else begin
			q_phase_reg <= q_phase_reg + 2'h1;
		end
	end
	assign q1 = (q_phase_reg == Q_PHASE_FIRST);
	assign q_phase_out = q_phase_reg;

	// Bus slave: one wait state, answer on the second cycle
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
	assign wr_en = avs_write_in & ack_reg & avs_byteenable_in[0];
	assign rd_first = avs_read_in & ~ack_reg;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
		end
	end

	assign pin_change_irq_flag = |pin_change_flags_in;
	always_comb begin
		flag0 = 8'h00;
		flag0[TIMER0_BIT] = timer0_irq_flag_reg;
		flag0[PIN_CHANGE_BIT] = pin_change_irq_flag;
		flag0[EXT_PIN_BIT] = ext_pin_irq_flag_reg;
		enable0 = 8'h00;
		enable0[TIMER0_BIT] = timer0_irq_enable_reg;
		enable0[PIN_CHANGE_BIT] = pin_change_irq_enable_reg;
		enable0[EXT_PIN_BIT] = ext_pin_irq_enable_reg;
		interrupt_control_view = 8'h00;
		interrupt_control_view[GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable_reg;
		interrupt_control_view[PERIPH_GROUP_IRQ_ENABLE_BIT] = periph_group_irq_enable_reg;
		interrupt_control_view[EXT_EDGE_POLARITY_BIT] = ext_edge_polarity_reg;
	end

	always_comb begin
		read_mux = 32'h0000_0000;
		if (reg_hit(avs_address_in, IDX_INTERRUPT_CONTROL)) begin
			read_mux[7:0] = interrupt_control_view;
		end else if (reg_hit(avs_address_in, IDX_PERIPHERAL_IRQ_ENABLE_0)) begin
			read_mux[7:0] = enable0;
		end else if (reg_hit(avs_address_in, IDX_PERIPHERAL_FLAG_0)) begin
			read_mux[7:0] = flag0;
		end else begin
			for (int i = 0; i < NUM_SHADOW; i++) begin
				if (reg_hit(avs_address_in, IDX_SHADOW_BASE + 12'(i))) begin
					read_mux[7:0] = shadow_reg[i];
				end
			end
		end
	end

	// Unmapped reads return zero
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			readdata_reg <= 32'h0000_0000;
		end else if (rd_first) begin
			readdata_reg <= read_mux;
		end
	end
	assign avs_readdata_out = readdata_reg;

	// Global enable: core entry and return outrank a software write
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			global_irq_enable_reg <= INTERRUPT_CONTROL_RESET[GLOBAL_IRQ_ENABLE_BIT];
		end else if (vector_taken_in) begin
			global_irq_enable_reg <= 1'b0;
		end else if (return_from_interrupt_in) begin
			global_irq_enable_reg <= 1'b1;
		end else if (wr_en && reg_hit(avs_address_in, IDX_INTERRUPT_CONTROL)) begin
			global_irq_enable_reg <= avs_writedata_in[GLOBAL_IRQ_ENABLE_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			periph_group_irq_enable_reg <= INTERRUPT_CONTROL_RESET[PERIPH_GROUP_IRQ_ENABLE_BIT];
			ext_edge_polarity_reg <= INTERRUPT_CONTROL_RESET[EXT_EDGE_POLARITY_BIT];
		end else if (wr_en && reg_hit(avs_address_in, IDX_INTERRUPT_CONTROL)) begin
			periph_group_irq_enable_reg <= avs_writedata_in[PERIPH_GROUP_IRQ_ENABLE_BIT];
			ext_edge_polarity_reg <= avs_writedata_in[EXT_EDGE_POLARITY_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer0_irq_enable_reg <= PERIPHERAL_IRQ_ENABLE_0_RESET[TIMER0_BIT];
			pin_change_irq_enable_reg <= PERIPHERAL_IRQ_ENABLE_0_RESET[PIN_CHANGE_BIT];
			ext_pin_irq_enable_reg <= PERIPHERAL_IRQ_ENABLE_0_RESET[EXT_PIN_BIT];
		end else if (wr_en && reg_hit(avs_address_in, IDX_PERIPHERAL_IRQ_ENABLE_0)) begin
			timer0_irq_enable_reg <= avs_writedata_in[TIMER0_BIT];
			pin_change_irq_enable_reg <= avs_writedata_in[PIN_CHANGE_BIT];
			ext_pin_irq_enable_reg <= avs_writedata_in[EXT_PIN_BIT];
		end
	end

	// Edge detector; first cycle after reset has no history, so no false edge
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ext_pin_prev_reg <= 1'b0;
			ext_prev_valid_reg <= 1'b0;
		end else begin
			ext_pin_prev_reg <= ext_pin_in;
			ext_prev_valid_reg <= 1'b1;
		end
	end
	assign ext_edge = ext_prev_valid_reg &&
		(ext_edge_polarity_reg ? (ext_pin_in & ~ext_pin_prev_reg)
		: (~ext_pin_in & ext_pin_prev_reg));

	// Flags set regardless of enables; set wins over a clearing write
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ext_pin_irq_flag_reg <= 1'b0;
		end else if (ext_edge) begin
			ext_pin_irq_flag_reg <= 1'b1;
		end else if (wr_en && reg_hit(avs_address_in, IDX_PERIPHERAL_FLAG_0)) begin
			ext_pin_irq_flag_reg <= avs_writedata_in[EXT_PIN_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer0_irq_flag_reg <= 1'b0;
		end else if (timer0_event_in) begin
			timer0_irq_flag_reg <= 1'b1;
		end else if (wr_en && reg_hit(avs_address_in, IDX_PERIPHERAL_FLAG_0)) begin
			timer0_irq_flag_reg <= avs_writedata_in[TIMER0_BIT];
		end
	end

	// One combined request, no priority between sources
	assign pending = (|(flag0 & enable0))
		| (periph_group_irq_enable_reg & |(periph_flags_in & periph_enables_in));
	assign wake_pending = |(flag0 & enable0 & WAKE_CAPABLE_MASK);

	// Sampled only at the first phase, so a late event waits a whole cycle
	// Held off while asleep and in the wake cycle, so the core runs one instruction first
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_req_reg <= 1'b0;
		end else if (vector_taken_in) begin
			irq_req_reg <= 1'b0;
		end else if (q1) begin
			irq_req_reg <= global_irq_enable_reg & pending & ~post_wake_reg
				& ~sleeping_in & ~wake_reg;
		end
	end
	assign irq_vector_req_out = irq_req_reg;

	// Wake pulse and one instruction cycle of grace after it
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= sleeping_in & wake_pending & ~wake_reg;
		end
	end
	assign wake_out = wake_reg;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			post_wake_reg <= 1'b0;
		end else if (wake_reg) begin
			post_wake_reg <= 1'b1;
		end else if (q1) begin
			post_wake_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			vector_addr_reg <= 15'h0000;
		end else if (vector_taken_in) begin
			vector_addr_reg <= IRQ_VECTOR_ADDR;
		end
	end
	assign irq_vector_addr_out = vector_addr_reg;

	// Shadow slots: entry capture beats a simultaneous software write
	for (genvar s = 0; s < NUM_SHADOW; s++) begin : g_shadow
		always_ff @(posedge clk_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				shadow_reg[s] <= SHADOW_RESET;
			end else if (vector_taken_in) begin
				shadow_reg[s] <= (s == SH_STATUS) ? (ctx_save_in[8*s +: 8] & STATUS_SAVE_MASK)
					: ctx_save_in[8*s +: 8];
			end else if (wr_en && reg_hit(avs_address_in, IDX_SHADOW_BASE + 12'(s))) begin
				shadow_reg[s] <= avs_writedata_in[7:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			restore_valid_reg <= 1'b0;
			ctx_restore_reg <= 64'h0000_0000_0000_0000;
		end else begin
			restore_valid_reg <= return_from_interrupt_in;
			if (return_from_interrupt_in) begin
				for (int i = 0; i < NUM_SHADOW; i++) begin
					ctx_restore_reg[8*i +: 8] <= shadow_reg[i];
				end
			end
		end
	end
	assign restore_valid_out = restore_valid_reg;
	assign ctx_restore_out = ctx_restore_reg;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	property p_flag_sets;
		timer0_event_in |=> timer0_irq_flag_reg;
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("timer0 flag not set");

	property p_entry;
		vector_taken_in |=> !global_irq_enable_reg && !irq_req_reg
			&& shadow_reg[SH_WORKING] == $past(ctx_save_in[7:0]);
	endproperty
	a_entry: assert property (p_entry) else $error("entry did not save or clear");

	property p_masked;
		q1 && !global_irq_enable_reg && !vector_taken_in |=> !irq_req_reg;
	endproperty
	a_masked: assert property (p_masked) else $error("request with enable clear");

	property p_return;
		return_from_interrupt_in && !vector_taken_in
			|=> global_irq_enable_reg && restore_valid_out
			&& ctx_restore_out[7:0] == $past(shadow_reg[SH_WORKING]);
	endproperty
	a_return: assert property (p_return) else $error("return did not restore");

	property p_q1_only;
		$rose(irq_req_reg) |-> $past(q_phase_reg) == Q_PHASE_FIRST;
	endproperty
	a_q1_only: assert property (p_q1_only) else $error("request outside first phase");

	property p_latency;
		global_irq_enable_reg && pending && !post_wake_reg && q1 && !vector_taken_in
			&& !sleeping_in && !wake_reg |=> irq_req_reg;
	endproperty
	a_latency: assert property (p_latency) else $error("pending source not requested");

	property p_edge;
		ext_prev_valid_reg && ext_edge_polarity_reg && ext_pin_in && !ext_pin_prev_reg
			|=> ext_pin_irq_flag_reg ##1 1'b1;
	endproperty
	a_edge: assert property (p_edge) else $error("rising edge missed");

	property p_wake_grace;
		wake_out |=> !irq_req_reg [*4];
	endproperty
	a_wake_grace: assert property (p_wake_grace) else $error("vector before next instruction");

	property p_sleep_block;
		q1 && (sleeping_in || wake_reg) |=> !irq_req_reg;
	endproperty
	a_sleep_block: assert property (p_sleep_block) else $error("request while asleep");

	property p_pin_change_read;
		ack_reg && avs_read_in && reg_hit(avs_address_in, IDX_PERIPHERAL_FLAG_0)
			|-> avs_readdata_out[PIN_CHANGE_BIT] == $past(pin_change_irq_flag);
	endproperty
	a_pin_change_read: assert property (p_pin_change_read) else $error("pin change flag wrong");

	property p_status_mask;
		vector_taken_in |=> (shadow_reg[SH_STATUS] & ~STATUS_SAVE_MASK) == 8'h00;
	endproperty
	a_status_mask: assert property (p_status_mask) else $error("status mask not applied");

endmodule // cic_interrupt_control

// ---- cic_pkg.sv ----
package cic_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_INTERRUPT_CONTROL = 12'h00B;
	localparam logic [11:0] IDX_PERIPHERAL_IRQ_ENABLE_0 = 12'h716;
	localparam logic [11:0] IDX_PERIPHERAL_FLAG_0 = 12'h70C;
	localparam logic [11:0] IDX_SHADOW_BASE = 12'hF80;
	localparam int NUM_SHADOW = 8;
	localparam int ADDR_W = 14;

	// Field positions
	localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
	localparam int PERIPH_GROUP_IRQ_ENABLE_BIT = 6;
	localparam int EXT_EDGE_POLARITY_BIT = 0;
	localparam int TIMER0_BIT = 5;
	localparam int PIN_CHANGE_BIT = 4;
	localparam int EXT_PIN_BIT = 0;

	// Reset values
	localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h01;
	localparam logic [7:0] PERIPHERAL_IRQ_ENABLE_0_RESET = 8'h00;
	localparam logic [7:0] SHADOW_RESET = 8'h00;

	// Status shadow drops the timeout and power-down bits
	localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;

	// Shadow slots within the context bus
	localparam int SH_WORKING = 0;
	localparam int SH_STATUS = 1;
	localparam int SH_BANK_SELECT = 2;
	localparam int SH_INDIRECT_0L = 3;
	localparam int SH_INDIRECT_0H = 4;
	localparam int SH_INDIRECT_1L = 5;
	localparam int SH_INDIRECT_1H = 6;
	localparam int SH_PC_HIGH = 7;

	localparam logic [14:0] IRQ_VECTOR_ADDR = 15'h0004;
	localparam logic [1:0] Q_PHASE_LAST = 2'h3;
	localparam logic [1:0] Q_PHASE_FIRST = 2'h0;
endpackage

// ---- cic_core_model.sv ----
`timescale 1ns/100ps
module cic_core_model (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic irq_req_in,
	input wire logic slow_in,
	input wire logic ret_cmd_in,
	input wire logic [63:0] ctx_in,
	output logic vector_taken_out,
	output logic [63:0] ctx_save_out,
	output logic return_out
);
	logic [1:0] state_reg;
	logic [2:0] stall_reg;
	// Context scrambled outside the taking pulse, so a late sample shows
	assign ctx_save_out = vector_taken_out ? ctx_in : ~ctx_in;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= 2'h0;
			stall_reg <= 3'h0;
			vector_taken_out <= 1'b0;
			return_out <= 1'b0;
		end else begin
			vector_taken_out <= 1'b0;
			return_out <= 1'b0;
			case (state_reg)
				2'h0: if (irq_req_in) begin
					stall_reg <= slow_in ? 3'h3 : 3'h0;
					state_reg <= 2'h1;
				end
				// A withdrawn request is not taken
				2'h1: if (!irq_req_in) begin
					state_reg <= 2'h0;
				end else if (stall_reg == 3'h0) begin
					vector_taken_out <= 1'b1;
					state_reg <= 2'h2;
				end else begin
					stall_reg <= stall_reg - 3'h1;
				end
				default: if (ret_cmd_in) begin
					return_out <= 1'b1;
					state_reg <= 2'h0;
				end
			endcase
		end
	end
endmodule // cic_core_model

// ---- cic_interrupt_control_bench.sv ----
`timescale 1ns/100ps
module cic_interrupt_control_bench;
	import cic_pkg::*;
	localparam logic [13:0] A_CTL = {IDX_INTERRUPT_CONTROL, 2'b00};
	localparam logic [13:0] A_EN = {IDX_PERIPHERAL_IRQ_ENABLE_0, 2'b00};
	localparam logic [13:0] A_FLG = {IDX_PERIPHERAL_FLAG_0, 2'b00};
	localparam logic [13:0] A_SH = {IDX_SHADOW_BASE, 2'b00};
	logic clk_in, reset_n_in, rd, wr, pin, tmr, vt, rfi, slp, slow, retc, req, wt, rv, wake;
	logic [13:0] adr;
	logic [31:0] wdat, rdat;
	logic [3:0] be;
	logic [7:0] pcf, m_ctrl, m_en, m_flg;
	logic [10:0] pf, pe;
	logic [1:0] qph;
	logic [14:0] vaddr;
	logic [63:0] ctx, ctx_s, ctx_r, e;
	logic [7:0] m_sh [8];
	int mismatches, checks, seed, i, c;

	cic_interrupt_control i_cic_interrupt_control (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
		.ext_pin_in(pin), .timer0_event_in(tmr), .pin_change_flags_in(pcf),
		.periph_flags_in(pf), .periph_enables_in(pe), .q_phase_out(qph),
		.irq_vector_req_out(req), .irq_vector_addr_out(vaddr), .vector_taken_in(vt),
		.ctx_save_in(ctx_s), .return_from_interrupt_in(rfi), .restore_valid_out(rv),
		.ctx_restore_out(ctx_r), .sleeping_in(slp), .wake_out(wake));
	cic_core_model i_cic_core_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .irq_req_in(req),
		.slow_in(slow), .ret_cmd_in(retc), .ctx_in(ctx), .vector_taken_out(vt),
		.ctx_save_out(ctx_s), .return_out(rfi));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic report_and_stop;
		if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
		checks++;
		if (s !== x) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, x, s);
		end
	endtask

	function automatic logic seen(input int s);
		case (s)
			0: return wt === 1'b0;
			1: return req === 1'b1;
			2: return vt === 1'b1;
			3: return rv === 1'b1;
			default: return wake === 1'b1;
		endcase
	endfunction

	// Every wait is bounded; a hang ends the run as a failure
	task automatic await(input int s, output int k);
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (!seen(s) && k < 20);
		if (!seen(s)) begin
			mismatches++;
			report_and_stop;
		end
	endtask

	task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_in);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= {24'h0, d};
		await(0, k);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic working_register(input logic [13:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
		if (be[0] !== 1'b1) return;
		if (a == A_CTL) m_ctrl = d & 8'hC1;
		if (a == A_EN) m_en = d & 8'h31;
		if (a == A_FLG) m_flg = d & 8'h21;
		if (a[13:5] == A_SH[13:5]) m_sh[a[4:2]] = d;
	endtask

	task automatic rdck(input logic [13:0] a);
		bus(1'b0, a, 8'h00);
		e = 64'h0;
		if (a == A_CTL) e[7:0] = m_ctrl;
		if (a == A_EN) e[7:0] = m_en;
		if (a == A_FLG) e[7:0] = m_flg | ((|pcf) ? 8'h10 : 8'h00);
		if (a[13:5] == A_SH[13:5]) e[7:0] = m_sh[a[4:2]];
		chk($sformatf("reg_%h", a), {32'h0, rdat}, e);
	endtask

	task automatic noreq(input int n);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge clk_in);
			if (req !== 1'b0) k++;
		end
		chk("idle_req", k, 0);
	endtask

	task automatic tpulse;
		@(posedge clk_in);
		tmr <= 1'b1;
		@(posedge clk_in);
		tmr <= 1'b0;
		m_flg[5] = 1'b1;
	endtask

	task automatic pin_to(input logic v);
		@(posedge clk_in);
		if (pin !== v && v === m_ctrl[0]) m_flg[0] = 1'b1;
		pin <= v;
		repeat (3) @(posedge clk_in);
	endtask

	task automatic isr;
		int k;
		await(2, k);
		m_ctrl[7] = 1'b0;
		for (k = 0; k < 8; k++) m_sh[k] = ctx[8*k +: 8] & (k == 1 ? STATUS_SAVE_MASK : 8'hFF);
		repeat (2) @(posedge clk_in);
		chk("vec_addr", vaddr, 64'h4);
		chk("req_after", req, 0);
		rdck(A_CTL);
		for (k = 0; k < 8; k++) rdck(A_SH + 14'(4*k));
		working_register(A_SH, 8'($random(seed)));
		working_register(A_FLG, 8'h00);
		pf <= 11'h0;
		pcf <= 8'h00;
		@(posedge clk_in);
		retc <= 1'b1;
		@(posedge clk_in);
		retc <= 1'b0;
		await(3, k);
		for (k = 0; k < 8; k++) e[8*k +: 8] = m_sh[k];
		chk("restore", ctx_r, e);
		m_ctrl[7] = 1'b1;
		rdck(A_CTL);
		ctx <= {$random(seed), $random(seed)};
	endtask

	initial begin
		seed = 58;
		mismatches = 0;
		checks = 0;
		{rd, wr, pin, tmr, slp, slow, retc} = '0;
		adr = '0;
		wdat = '0;
		be = 4'hF;
		pcf = '0;
		pf = '0;
		pe = '0;
		ctx = {$random(seed), $random(seed)};
		m_ctrl = 8'h01;
		m_en = 8'h00;
		m_flg = 8'h00;
		foreach (m_sh[k]) m_sh[k] = 8'h00;
		reset_n_in = 1'b0;
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		chk("req_rst", req, 0);
		rdck(A_CTL);
		rdck(A_EN);
		rdck(A_FLG);
		for (i = 0; i < 8; i++) rdck(A_SH + 14'(4*i));
		rdck(14'h0100);
		for (i = 0; i < 4; i++) begin
			working_register(A_CTL, 8'($random(seed)) & 8'h7F);
			rdck(A_CTL);
			working_register(A_EN, 8'($random(seed)));
			rdck(A_EN);
		end
		be <= 4'h0;
		working_register(A_CTL, 8'hC0);
		be <= 4'hF;
		rdck(A_CTL);
		working_register(A_CTL, 8'h00);
		working_register(A_EN, 8'h00);
		working_register(A_FLG, 8'h00);
		tpulse;
		rdck(A_FLG);
		for (i = 1; i >= 0; i--) begin
			working_register(A_CTL, 8'(i));
			pin_to(!i[0]);
			working_register(A_FLG, 8'h00);
			pin_to(i[0]);
			rdck(A_FLG);
			working_register(A_FLG, 8'h00);
			pin_to(!i[0]);
			rdck(A_FLG);
		end
		pcf <= 8'($random(seed)) | 8'h01;
		rdck(A_FLG);
		working_register(A_FLG, 8'h00);
		rdck(A_FLG);
		pcf <= 8'h00;
		rdck(A_FLG);
		pe <= 11'h7FF;
		pf <= 11'h400;
		working_register(A_CTL, 8'h80);
		noreq(12);
		slow <= 1'b1;
		working_register(A_CTL, 8'hC0);
		isr;
		slow <= 1'b0;
		working_register(A_CTL, 8'h01);
		working_register(A_EN, 8'h01);
		pin_to(1'b0);
		pin_to(1'b1);
		noreq(8);
		working_register(A_CTL, 8'h81);
		isr;
		working_register(A_EN, 8'h20);
		tpulse;
		await(1, c);
		chk("latency", c >= 2 && c <= 5, 1);
		chk("phase", qph, 2'h1);
		isr;
		working_register(A_EN, 8'h11);
		slp <= 1'b1;
		pcf <= 8'h80;
		await(4, c);
		slp <= 1'b0;
		c = 0;
		i = (req !== 1'b0);
		while (qph !== 2'h0 && c < 8) begin
			@(posedge clk_in);
			c++;
			if (req !== 1'b0) i++;
		end
		@(posedge clk_in);
		chk("wake_block", req | (i != 0), 0);
		chk("wake_phase", qph, 2'h1);
		isr;
		working_register(A_CTL, 8'hC1);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		m_ctrl = 8'h01;
		m_en = 8'h00;
		m_flg = 8'h00;
		foreach (m_sh[k]) m_sh[k] = 8'h00;
		chk("req_rst2", req, 0);
		rdck(A_CTL);
		report_and_stop;
	end
endmodule // cic_interrupt_control_bench
